// *** logic/pcl_pkg.sv ***
// Constants and carrier types for the PHY configuration and indicator block.
// Assumes a 125 MHz device clock and 16-bit management register accesses.
package pcl_pkg;

    // Management register addresses
    localparam logic [4:0] ADDR_LINK_CTL  = 5'h19;
    localparam logic [4:0] ADDR_SB_CFG    = 5'h1a;
    localparam logic [4:0] ADDR_SA_LOW_LO = 5'h1b;
    localparam logic [4:0] ADDR_SA_LOW_HI = 5'h1c;
    localparam logic [4:0] ADDR_SA_HIGH   = 5'h1d;
    localparam logic [4:0] ADDR_IND_CFG   = 5'h1e;

    // link_control_bits fields
    localparam int LC_ANEG_RESTART = 10;
    localparam int LC_GIG_DIS      = 6;
    localparam int LC_LPLU         = 2;

    // sideband_bus_config fields
    localparam int SB_FREQ_HI    = 12;
    localparam int SB_FRAG       = 11;
    localparam int SB_APM        = 10;
    localparam int SB_PEC        = 9;
    localparam int SB_FREQ_LO    = 8;
    localparam int SB_ADDR_VALID = 7;
    localparam int SB_ADDR_LSB   = 0;

    // indicator_config fields; channel n starts at bit n*IND_STRIDE
    localparam int IND_RATE     = 15;
    localparam int IND_STRIDE   = 5;
    localparam int IND_MODE_LSB = 0;
    localparam int IND_POL      = 3;
    localparam int IND_BLINK    = 4;

    // Reset values and write masks
    localparam logic [15:0] LINK_CTL_RST = 16'h0000;
    localparam logic [15:0] SB_CFG_RST   = 16'h0200;
    localparam logic [15:0] SB_CFG_WMASK = 16'h1fff;
    localparam logic [15:0] IND_CFG_RST  = 16'h18f4;
    localparam logic [15:0] SA_HIGH_RST  = 16'h0000;
    localparam logic [31:0] SA_LOW_RST   = 32'h0000_0000;

    // Non-volatile memory words that hold the station address
    localparam logic [7:0] NVM_SA_W0 = 8'h00;
    localparam logic [7:0] NVM_SA_W1 = 8'h01;
    localparam logic [7:0] NVM_SA_W2 = 8'h02;

    // Blink timing
    localparam int CLK_KHZ        = 125000;
    localparam int BLINK_SLOW_MS  = 200;
    localparam int BLINK_FAST_MS  = 83;
    localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_KHZ;
    localparam int BLINK_FAST_CYC = BLINK_FAST_MS * CLK_KHZ;
    localparam int BLINK_CNT_W    = 25;

    typedef enum logic [1:0] {
        PCL_SPD_10   = 2'h0,
        PCL_SPD_100  = 2'h1,
        PCL_SPD_1000 = 2'h2
    } pcl_speed_t;

    typedef enum logic [1:0] {
        PCL_SMB_100K  = 2'h0,
        PCL_SMB_400K  = 2'h1,
        PCL_SMB_1000K = 2'h2,
        PCL_SMB_RSVD  = 2'h3
    } pcl_smb_freq_t;

    typedef enum logic [2:0] {
        PCL_IND_LINK_10_1000  = 3'h0,
        PCL_IND_LINK_100_1000 = 3'h1,
        PCL_IND_LINK_ANY      = 3'h2,
        PCL_IND_ACTIVITY      = 3'h3,
        PCL_IND_LINK_IDLE     = 3'h4,
        PCL_IND_LINK_10       = 3'h5,
        PCL_IND_LINK_100      = 3'h6,
        PCL_IND_LINK_1000     = 3'h7
    } pcl_ind_mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pcl_mgmt_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } pcl_mgmt_rsp_t;

    typedef struct packed {
        logic       up;
        pcl_speed_t speed;
        logic       activity;
    } pcl_link_st_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  word;
        logic [15:0] data;
    } pcl_nvm_wr_t;

    typedef struct packed {
        logic          frag_64;
        logic          pec_en;
        logic          apm_en;
        pcl_smb_freq_t freq;
        logic          addr_valid;
        logic [6:0]    target;
    } pcl_smb_cfg_t;

    typedef struct packed {
        logic [15:0]            link_ctl;
        logic [15:0]            sb_cfg;
        logic [31:0]            sa_low;
        logic [15:0]            sa_high;
        logic [15:0]            ind_cfg;
        logic [BLINK_CNT_W-1:0] blink_cnt;
        logic                   blink_phase;
        logic                   host_rst_n_q;
        logic                   rvalid;
        logic [15:0]            rdata;
        logic [2:0]             ind;
    } pcl_state_t;

endpackage

// *** logic/pcl_regs.sv ***
// PHY configuration register bank with link, sideband bus and indicator control.
// Assumes all inputs are synchronous to mclk; arst_n is the power-on reset.
`timescale 1ns/1ps

// Operation
// - Restart bit starts negotiation, then self-clears
// - Gigabit disable bit forbids 1000 Mb/s
// - Gigabit disable zero at reset, set on fallback
// - Low-power bit brings link at lowest speed
// - Fragment bit selects 64 or 32 bytes
// - Two bits select 100/400/1000 kHz bus
// - PEC bit enables error checking, resets one
// - Seven-bit field is bus master target
// - Sideband config reset only at power-on
// - Low address from memory words 0, 1
// - High address from memory word 2
// - Blink 200 ms or 83 ms per rate
// - Polarity bit: zero low, one high
// - Three-bit mode field per indicator channel
// - Link modes select speeds shown
// - Activity mode: link up with traffic
// - Idle mode: link up without traffic
module pcl_regs #(
    parameter int BLINK_SLOW = pcl_pkg::BLINK_SLOW_CYC,
    parameter int BLINK_FAST = pcl_pkg::BLINK_FAST_CYC,
    parameter int N_IND      = 3
) (
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    input  wire logic                   phy_soft_reset,
    input  wire logic                   host_port_reset_n,
    input  wire pcl_pkg::pcl_mgmt_req_t mgmt_req,
    output      pcl_pkg::pcl_mgmt_rsp_t mgmt_rsp,
    input  wire pcl_pkg::pcl_nvm_wr_t   nvm_wr,
    input  wire pcl_pkg::pcl_link_st_t  link_st,
    output      logic                   aneg_restart,
    output      logic                   gigabit_disable,
    output      logic                   low_power_linkup,
    output      pcl_pkg::pcl_smb_cfg_t  smb_cfg,
    input  wire logic                   smb_txn_req,
    output      logic                   smb_txn_start,
    output      logic [N_IND-1:0]       ind_pin
);
    import pcl_pkg::*;

    localparam logic [BLINK_CNT_W-1:0] SLOW_LIM = BLINK_CNT_W'(BLINK_SLOW - 1);
    localparam logic [BLINK_CNT_W-1:0] FAST_LIM = BLINK_CNT_W'(BLINK_FAST - 1);

    pcl_state_t st_q;
    pcl_state_t st_d;
    logic [N_IND-1:0] ind_cond;

    // Condition that lights one channel, before blink and polarity
    function automatic logic ind_active(input logic [2:0] mode, input pcl_link_st_t ls);
        logic l10;
        logic l100;
        logic l1000;
        logic r;
        l10   = ls.up && (ls.speed == PCL_SPD_10);
        l100  = ls.up && (ls.speed == PCL_SPD_100);
        l1000 = ls.up && (ls.speed == PCL_SPD_1000);
        case (mode)
            PCL_IND_LINK_10_1000:  r = l10 || l1000;
            PCL_IND_LINK_100_1000: r = l100 || l1000;
            PCL_IND_LINK_ANY:      r = ls.up;
            PCL_IND_ACTIVITY:      r = ls.up && ls.activity;
            PCL_IND_LINK_IDLE:     r = ls.up && !ls.activity;
            PCL_IND_LINK_10:       r = l10;
            PCL_IND_LINK_100:      r = l100;
            PCL_IND_LINK_1000:     r = l1000;
            default:               r = 1'b0;
        endcase
        return r;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < N_IND; gi++) begin : g_ind
            // Mode field of channel gi
            assign ind_cond[gi] = ind_active(
                st_q.ind_cfg[gi*IND_STRIDE+IND_MODE_LSB +: 3], link_st);
        end
    endgenerate

    always_comb begin
        logic [BLINK_CNT_W-1:0] lim;
        logic [15:0]            rd;
        logic                   on;
        st_d = st_q;
        lim  = '0;
        rd   = 16'h0000;
        on   = 1'b0;

        // Restart bit lives one cycle; a fresh write below wins the same cycle
        st_d.link_ctl[LC_ANEG_RESTART] = 1'b0;

        if (phy_soft_reset) begin
            // Sideband config deliberately untouched here
            st_d.link_ctl = LINK_CTL_RST;
            st_d.ind_cfg  = IND_CFG_RST;
        end

        if (mgmt_req.wr) begin
            case (mgmt_req.addr)
                ADDR_LINK_CTL:  st_d.link_ctl = mgmt_req.wdata;
                ADDR_SB_CFG:    st_d.sb_cfg = mgmt_req.wdata & SB_CFG_WMASK;
                ADDR_SA_LOW_LO: st_d.sa_low[15:0] = mgmt_req.wdata;
                ADDR_SA_LOW_HI: st_d.sa_low[31:16] = mgmt_req.wdata;
                ADDR_SA_HIGH:   st_d.sa_high = mgmt_req.wdata;
                ADDR_IND_CFG:   st_d.ind_cfg = mgmt_req.wdata;
                default:        st_d.rvalid = st_d.rvalid;
            endcase
        end

        // Memory loader overrides a management write to the same half word
        if (nvm_wr.valid) begin
            case (nvm_wr.word)
                NVM_SA_W0: st_d.sa_low[15:0] = nvm_wr.data;
                NVM_SA_W1: st_d.sa_low[31:16] = nvm_wr.data;
                NVM_SA_W2: st_d.sa_high = nvm_wr.data;
                default:   st_d.sa_high = st_d.sa_high;
            endcase
        end

        // Fallback to the sideband path forces gigabit off, over any write
        st_d.host_rst_n_q = host_port_reset_n;
        if (st_q.host_rst_n_q && !host_port_reset_n) begin
            st_d.link_ctl[LC_GIG_DIS] = 1'b1;
        end

        case (mgmt_req.addr)
            ADDR_LINK_CTL:  rd = st_q.link_ctl;
            ADDR_SB_CFG:    rd = st_q.sb_cfg;
            ADDR_SA_LOW_LO: rd = st_q.sa_low[15:0];
            ADDR_SA_LOW_HI: rd = st_q.sa_low[31:16];
            ADDR_SA_HIGH:   rd = st_q.sa_high;
            ADDR_IND_CFG:   rd = st_q.ind_cfg;
            default:        rd = 16'h0000;
        endcase
        st_d.rvalid = mgmt_req.rd;
        if (mgmt_req.rd) begin
            st_d.rdata = rd;
        end

        // Shared blink timebase; a rate change takes effect at the next compare
        lim = st_q.ind_cfg[IND_RATE] ? FAST_LIM : SLOW_LIM;
        if (st_q.blink_cnt >= lim) begin
            st_d.blink_cnt   = '0;
            st_d.blink_phase = !st_q.blink_phase;
        end else begin
            st_d.blink_cnt = st_q.blink_cnt + 1'b1;
        end

        for (int i = 0; i < N_IND; i++) begin
            on = ind_cond[i];
            if (st_q.ind_cfg[i*IND_STRIDE+IND_BLINK]) begin
                on = on && st_q.blink_phase;
            end
            // Polarity zero drives the pin low when lit
            st_d.ind[i] = st_q.ind_cfg[i*IND_STRIDE+IND_POL] ? on : !on;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q.link_ctl     <= LINK_CTL_RST;
            st_q.sb_cfg       <= SB_CFG_RST;
            st_q.sa_low       <= SA_LOW_RST;
            st_q.sa_high      <= SA_HIGH_RST;
            st_q.ind_cfg      <= IND_CFG_RST;
            st_q.blink_cnt    <= '0;
            st_q.blink_phase  <= 1'b0;
            st_q.host_rst_n_q <= 1'b1;
            st_q.rvalid       <= 1'b0;
            st_q.rdata        <= 16'h0000;
            st_q.ind          <= 3'h7;
        end else begin
            st_q <= st_d;
        end
    end

    assign mgmt_rsp.rvalid  = st_q.rvalid;
    assign mgmt_rsp.rdata   = st_q.rdata;
    assign aneg_restart     = st_q.link_ctl[LC_ANEG_RESTART];
    assign gigabit_disable  = st_q.link_ctl[LC_GIG_DIS];
    assign low_power_linkup = st_q.link_ctl[LC_LPLU];

    assign smb_cfg.frag_64    = st_q.sb_cfg[SB_FRAG];
    assign smb_cfg.pec_en     = st_q.sb_cfg[SB_PEC];
    assign smb_cfg.apm_en     = st_q.sb_cfg[SB_APM];
    assign smb_cfg.freq       = pcl_smb_freq_t'({st_q.sb_cfg[SB_FREQ_HI],
                                                 st_q.sb_cfg[SB_FREQ_LO]});
    assign smb_cfg.addr_valid = st_q.sb_cfg[SB_ADDR_VALID];
    assign smb_cfg.target     = st_q.sb_cfg[SB_ADDR_LSB +: 7];

    // Master requests are held off until the partner address is declared valid
    assign smb_txn_start = smb_txn_req && st_q.sb_cfg[SB_ADDR_VALID];

    assign ind_pin = st_q.ind[N_IND-1:0];

endmodule

// *** verification/pcl_regs_checker.sv ***
// Port assertions for the PHY configuration bank.
// Assumes one clock domain and power-on reset on arst_n.
`timescale 1ns/1ps
module pcl_regs_checker #(
    parameter int N_IND = 3
) (
    input wire logic                   mclk,
    input wire logic                   arst_n,
    input wire logic                   phy_soft_reset,
    input wire logic                   host_port_reset_n,
    input wire pcl_pkg::pcl_mgmt_req_t mgmt_req,
    input wire pcl_pkg::pcl_mgmt_rsp_t mgmt_rsp,
    input wire logic                   aneg_restart,
    input wire logic                   gigabit_disable,
    input wire logic                   low_power_linkup,
    input wire pcl_pkg::pcl_smb_cfg_t  smb_cfg,
    input wire logic                   smb_txn_req,
    input wire logic                   smb_txn_start,
    input wire logic [N_IND-1:0]       ind_pin
);
    import pcl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_ctl_wr;
        mgmt_req.wr && mgmt_req.addr == ADDR_LINK_CTL;
    endsequence
    sequence s_pulse;
        aneg_restart ##1 !aneg_restart;
    endsequence
    a_restart_pulse: assert property (
        s_ctl_wr ##0 mgmt_req.wdata[LC_ANEG_RESTART] ##1 !mgmt_req.wr |-> s_pulse)
        else $error("restart pulse wrong");
    a_restart_cause: assert property (
        aneg_restart |-> $past(mgmt_req.wr && mgmt_req.addr == ADDR_LINK_CTL
                               && mgmt_req.wdata[LC_ANEG_RESTART]))
        else $error("restart without write");
    a_gig_fallback: assert property (
        $fell(host_port_reset_n) |=> gigabit_disable)
        else $error("fallback did not set gigabit disable");
    a_ctl_write: assert property (
        s_ctl_wr ##0 !phy_soft_reset ##0 !$fell(host_port_reset_n) |=>
        gigabit_disable == $past(mgmt_req.wdata[LC_GIG_DIS])
        && low_power_linkup == $past(mgmt_req.wdata[LC_LPLU]))
        else $error("control bits not written");
    a_start_gate: assert property (
        smb_txn_start == (smb_txn_req && smb_cfg.addr_valid))
        else $error("sideband start not gated");
    a_sb_fields: assert property (
        mgmt_req.wr && mgmt_req.addr == ADDR_SB_CFG |=>
        smb_cfg.target == $past(mgmt_req.wdata[6:0])
        && smb_cfg.frag_64 == $past(mgmt_req.wdata[SB_FRAG])
        && smb_cfg.pec_en == $past(mgmt_req.wdata[SB_PEC])
        && smb_cfg.freq == {$past(mgmt_req.wdata[SB_FREQ_HI]), $past(mgmt_req.wdata[SB_FREQ_LO])})
        else $error("sideband fields wrong");
    a_sb_keep: assert property (
        phy_soft_reset && !mgmt_req.wr |=> $stable(smb_cfg))
        else $error("sideband config lost on soft reset");
    a_read_answer: assert property (
        mgmt_req.rd |=> mgmt_rsp.rvalid)
        else $error("read not answered");
endmodule
bind pcl_regs pcl_regs_checker #(.N_IND(N_IND)) chk_u (.mclk, .arst_n, .phy_soft_reset,
    .host_port_reset_n, .mgmt_req, .mgmt_rsp, .aneg_restart, .gigabit_disable,
    .low_power_linkup, .smb_cfg, .smb_txn_req, .smb_txn_start, .ind_pin);

// *** verification/pcl_lan_model.sv ***
// Controller-side loader replaying the station address words.
// Assumes go is a one-cycle pulse; data is scrambled while idle.
`timescale 1ns/1ps
module pcl_lan_model #(
    parameter logic [47:0] STATION = 48'h0a1b_2c3d_4e5f
) (
    input  wire logic                 mclk,
    input  wire logic                 go,
    output      pcl_pkg::pcl_nvm_wr_t nvm_wr
);
    import pcl_pkg::*;
    logic [1:0] step = 2'h3;
    always @(posedge mclk) begin
        if (go) step <= 2'h0;
        else if (step != 2'h3) step <= step + 2'h1;
    end
    // Words 0 and 1 carry the low part, word 2 the high part
    assign nvm_wr.valid = step != 2'h3;
    assign nvm_wr.word = {6'h0, step};
    assign nvm_wr.data = nvm_wr.valid ? STATION[step*16 +: 16] : ~STATION[15:0];
endmodule

// *** verification/pcl_regs_bench.sv ***
// Self-checking bench for the PHY configuration and indicator bank.
// Assumes blink counts shortened to 8 and 4 cycles.
`timescale 1ns/1ps
module pcl_regs_bench;
    import pcl_pkg::*;
    localparam logic [47:0] SA = 48'h0a1b_2c3d_4e5f;
    logic          mclk;
    logic          arst_n;
    logic          soft_rst;
    logic          host_rst_n;
    logic          txn_req;
    logic          go;
    logic          aneg;
    logic          gdis;
    logic          lplu;
    logic          start;
    logic [2:0]    pin;
    logic [15:0]   v;
    pcl_mgmt_req_t req;
    pcl_mgmt_rsp_t rsp;
    pcl_nvm_wr_t   nvm;
    pcl_link_st_t  lst;
    pcl_smb_cfg_t  scfg;
    int            error_cnt = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    pcl_regs #(.BLINK_SLOW(8), .BLINK_FAST(4)) dut_u (.mclk(mclk), .arst_n(arst_n),
        .phy_soft_reset(soft_rst), .host_port_reset_n(host_rst_n), .mgmt_req(req),
        .mgmt_rsp(rsp), .nvm_wr(nvm), .link_st(lst), .aneg_restart(aneg),
        .gigabit_disable(gdis), .low_power_linkup(lplu), .smb_cfg(scfg),
        .smb_txn_req(txn_req), .smb_txn_start(start), .ind_pin(pin));
    pcl_lan_model #(.STATION(SA)) lan_u (.mclk(mclk), .go(go), .nvm_wr(nvm));
    task automatic complete_run;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk) req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge mclk) req <= '{1'b0, 1'b1, a, 16'h0};
        @(posedge mclk) req.rd <= 1'b0;
        #1;
        chk("rvalid", 16'h1, {15'h0, rsp.rvalid});
        chk("rdata", e, rsp.rdata);
    endtask
    function automatic logic ind_on(input logic [2:0] m, input pcl_link_st_t s);
        logic a;
        logic b;
        logic c;
        a = s.up && s.speed == PCL_SPD_10;
        b = s.up && s.speed == PCL_SPD_100;
        c = s.up && s.speed == PCL_SPD_1000;
        case (m)
            3'h0: ind_on = a | c;
            3'h1: ind_on = b | c;
            3'h2: ind_on = s.up;
            3'h3: ind_on = s.up & s.activity;
            3'h4: ind_on = s.up & ~s.activity;
            3'h5: ind_on = a;
            3'h6: ind_on = b;
            default: ind_on = c;
        endcase
    endfunction
    // First interval may include a config change, so only the second counts
    task automatic half(input int e);
        int n;
        logic b;
        repeat (2) begin
            n = 0;
            b = pin[2];
            while (pin[2] === b && n < 40) begin
                tick;
                n++;
            end
        end
        chk("blink", 16'(e), 16'(n));
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run;
        end
    end
    initial begin
        arst_n = 1'b0;
        soft_rst = 1'b0;
        host_rst_n = 1'b1;
        txn_req = 1'b0;
        go = 1'b0;
        req = '0;
        lst = '0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        rd(ADDR_LINK_CTL, 16'h0000);
        rd(ADDR_SB_CFG, 16'h0200);
        rd(ADDR_IND_CFG, 16'h18f4);
        rd(5'h05, 16'h0000);
        $display("done reset");
        wr(ADDR_LINK_CTL, 16'h0444);
        chk("restart", 16'h1, {15'h0, aneg});
        chk("gig_dis", 16'h1, {15'h0, gdis});
        chk("lplu", 16'h1, {15'h0, lplu});
        rd(ADDR_LINK_CTL, 16'h0044);
        wr(ADDR_LINK_CTL, 16'h0000);
        chk("gig_clr", 16'h0, {15'h0, gdis});
        @(posedge mclk) host_rst_n <= 1'b0;
        tick;
        tick;
        chk("fallback", 16'h1, {15'h0, gdis});
        @(posedge mclk) host_rst_n <= 1'b1;
        $display("done link");
        for (int f = 0; f < 4; f++) begin
            v = {3'h0, f[1], 3'b101, f[0], 1'b1, 7'h2a};
            wr(ADDR_SB_CFG, v);
            chk("freq", 16'(f), {14'h0, scfg.freq});
        end
        chk("frag", 16'h1, {15'h0, scfg.frag_64});
        chk("pec", 16'h1, {15'h0, scfg.pec_en});
        chk("target", 16'h2a, {9'h0, scfg.target});
        wr(ADDR_SB_CFG, 16'hffff);
        rd(ADDR_SB_CFG, 16'h1fff);
        chk("apm", 16'h1, {15'h0, scfg.apm_en});
        chk("valid", 16'h1, {15'h0, scfg.addr_valid});
        @(posedge mclk) txn_req <= 1'b1;
        #1;
        chk("start", 16'h1, {15'h0, start});
        wr(ADDR_SB_CFG, 16'h002a);
        chk("no_start", 16'h0, {15'h0, start});
        chk("frag32", 16'h0, {15'h0, scfg.frag_64});
        wr(ADDR_LINK_CTL, 16'h0040);
        wr(ADDR_IND_CFG, 16'h0000);
        @(posedge mclk) soft_rst <= 1'b1;
        @(posedge mclk) soft_rst <= 1'b0;
        rd(ADDR_LINK_CTL, 16'h0000);
        rd(ADDR_SB_CFG, 16'h002a);
        rd(ADDR_IND_CFG, 16'h18f4);
        $display("done sideband");
        wr(ADDR_SA_HIGH, 16'h1234);
        rd(ADDR_SA_HIGH, 16'h1234);
        @(posedge mclk) go <= 1'b1;
        @(posedge mclk) go <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(ADDR_SA_LOW_LO, SA[15:0]);
        rd(ADDR_SA_LOW_HI, SA[31:16]);
        rd(ADDR_SA_HIGH, SA[47:32]);
        $display("done address");
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_IND_CFG, {8'h0, m[2:0], 2'b01, m[2:0]});
            for (int s = 0; s < 7; s++) begin
                @(posedge mclk) lst <= '{s < 6, pcl_speed_t'(s % 6 / 2), s[0]};
                tick;
                v[0] = ind_on(m[2:0], lst);
                chk("ind_hi", {15'h0, v[0]}, {15'h0, pin[0]});
                chk("ind_lo", {15'h0, ~v[0]}, {15'h0, pin[1]});
            end
        end
        @(posedge mclk) lst <= '{1'b1, PCL_SPD_1000, 1'b1};
        wr(ADDR_IND_CFG, 16'h4c00);
        half(8);
        wr(ADDR_IND_CFG, 16'hcc00);
        half(4);
        $display("done indicators");
        // Power-on reset in mid-run must restore what the soft reset keeps
        wr(ADDR_LINK_CTL, 16'h0040);
        @(posedge mclk) arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(ADDR_LINK_CTL, 16'h0000);
        rd(ADDR_SB_CFG, 16'h0200);
        rd(ADDR_SA_HIGH, 16'h0000);
        $display("done power-on reset");
        complete_run;
    end
endmodule
